/* hdl/shift_unit_pkg.sv */
// Package for the universal serial shift unit: modes, widths, counts, carriers.
// Assumes a single-clock core domain plus a link clock of its own, apart from the shift clock pin.
package shift_unit_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CNT_W = 4;
   localparam logic [7:0] SHIFT_RST = 8'h00;
   localparam logic [3:0] CNT_RST = 4'h0;
   localparam logic [3:0] CNT_MAX = 4'hf;
   localparam logic [3:0] CNT_ACK_PRELOAD = 4'he;
   localparam int unsigned MSB_POS = 7;
   localparam int unsigned SYNC_STAGES = 2;
   localparam int unsigned CORE_CLK_HZ = 20000000;

   typedef enum logic [1:0]
   {
      WIRE_OFF = 2'h0,
      WIRE_THREE = 2'h1,
      WIRE_TWO = 2'h2,
      WIRE_TWO_HOLD = 2'h3
   } wire_mode_e;

   typedef enum logic [2:0]
   {
      HOLD_IDLE = 3'b001,
      HOLD_START = 3'b010,
      HOLD_ARMED = 3'b100
   } hold_state_e;

   // Software control word, applied as one write.
   typedef struct packed
   {
      wire_mode_e wire_mode;
      logic external_clock_select;
      logic clock_edge_select;
      logic counter_strobe_select;
      logic clock_toggle_strobe;
   } serial_control_s;

   // Status seen by software.
   typedef struct packed
   {
      logic start_detect_flag;
      logic count_overflow_flag;
      logic [3:0] count;
   } serial_status_s;
endpackage

/* hdl/universal_serial_shift_unit.sv */
// Universal serial shift unit: 8-bit shift register, 4-bit edge counter,
// three-wire and two-wire operation with start detect and clock hold.
// Assumes pins arrive asynchronously; the link clock is its own port, apart from the shift clock pin.
`timescale 1ns/100ps
`default_nettype none
module universal_serial_shift_unit
   import shift_unit_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic link_clk,
   input wire serial_control_s ctrl,
   input wire logic ctrl_wr,
   input wire logic [7:0] data_wr,
   input wire logic data_wr_en,
   input wire logic [3:0] count_wr,
   input wire logic count_wr_en,
   input wire logic clear_overflow,
   input wire logic clear_start,
   input wire logic port_clk_bit,
   input wire logic port_data_bit,
   input wire logic clk_dir,
   input wire logic data_dir,
   input wire logic serial_data_in,
   input wire logic shift_clock_in,
   output logic shift_clock_out,
   output logic shift_clock_oe,
   output logic serial_data_out,
   output logic serial_data_oe,
   output logic [7:0] shift_register,
   output serial_status_s serial_status_reg,
   output logic wake_idle
);

   ////////////////////////////////////////////////////////////////////////////
   // Configuration and pin synchronisers.

   serial_control_s cfg_r;
   logic [1:0] sck_sync_r;
   logic [1:0] sda_sync_r;
   logic sck_q_r;
   logic sda_q_r;
   logic toggle_r;
   logic [1:0] lk_sync_r;
   logic lk_q_r;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cfg_r <= '0;
      end
      else if (clk_en && ctrl_wr)
      begin
         cfg_r <= ctrl;
      end
   end

   // Shift clock pin is sampled in the core domain; link clock activity arrives via the link domain toggle.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sck_sync_r <= 2'h0;
         sda_sync_r <= 2'h3;
         sck_q_r <= 1'b0;
         sda_q_r <= 1'b1;
         lk_sync_r <= 2'h0;
         lk_q_r <= 1'b0;
      end
      else if (clk_en)
      begin
         sck_sync_r <= {sck_sync_r[0], shift_clock_in};
         sda_sync_r <= {sda_sync_r[0], serial_data_in};
         sck_q_r <= sck_sync_r[1];
         sda_q_r <= sda_sync_r[1];
         lk_sync_r <= {lk_sync_r[0], toggle_r};
         lk_q_r <= lk_sync_r[1];
      end
   end

   // Link-domain activity marker: toggles on each link clock rising edge.
   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         toggle_r <= 1'b0;
      end
      else
      begin
         toggle_r <= ~toggle_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock source and edge decode.

   wire logic two_wire = cfg_r.wire_mode[1];
   wire logic sck_rise = sck_sync_r[1] & ~sck_q_r;
   wire logic sck_fall = ~sck_sync_r[1] & sck_q_r;
   wire logic sck_edge = sck_rise | sck_fall;
   wire logic sw_strobe = clk_en & ctrl_wr;
   wire logic link_seen = lk_sync_r[1] ^ lk_q_r;
   // Sample and shift edges follow the edge select in external clock mode.
   wire logic ext_sample = cfg_r.clock_edge_select ? sck_fall : sck_rise;
   wire logic ext_shift = cfg_r.clock_edge_select ? sck_rise : sck_fall;
   // Software clock: counter strobe select shifts on the control write itself.
   wire logic sw_shift = sw_strobe & ctrl.counter_strobe_select & ~ctrl.external_clock_select;
   wire logic ext_sel = cfg_r.external_clock_select;
   wire logic do_sample = ext_sel ? ext_sample : sw_shift;
   // Counter advances on both pin edges, or on a strobe when selected.
   wire logic strobe_count = sw_strobe & ctrl.external_clock_select
                            & ctrl.counter_strobe_select & ctrl.clock_toggle_strobe;
   wire logic cnt_tick = (ext_sel & sck_edge & ~cfg_r.counter_strobe_select)
                         | strobe_count | sw_shift;

   ////////////////////////////////////////////////////////////////////////////
   // Shift register and counter.

   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic in_bit_r;
   logic out_latch_r;
   logic ovf_r;
   logic start_r;
   logic clk_pin_r;
   hold_state_e hold_r;
   hold_state_e hold_nxt;
   logic ovf_hold_r;

   wire logic wrap = cnt_tick & (cnt_r == CNT_MAX);
   // A software write wins over a shift in the same cycle (unbuffered register).
   assign shift_nxt = data_wr_en ? data_wr
                    : do_sample ? {shift_r[6:0], sda_sync_r[1]}
                    : shift_r;
   assign cnt_nxt = count_wr_en ? count_wr
                  : cnt_tick ? cnt_r + 4'h1
                  : cnt_r;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_r <= SHIFT_RST;
         cnt_r <= CNT_RST;
      end
      else if (clk_en)
      begin
         shift_r <= shift_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Output latch opens on the shift edge or a data write in external mode, stays open otherwise.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         out_latch_r <= 1'b1;
      end
      else if (clk_en && (!ext_sel || ext_shift || data_wr_en))
      begin
         out_latch_r <= shift_nxt[MSB_POS];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags; a set in the same cycle as a clear wins.

   wire logic start_seen = two_wire & sck_sync_r[1] & sck_q_r
                           & ~sda_sync_r[1] & sda_q_r;

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ovf_r <= 1'b0;
         start_r <= 1'b0;
      end
      else if (clk_en)
      begin
         ovf_r <= wrap | (ovf_r & ~clear_overflow);
         start_r <= start_seen | (start_r & ~clear_start);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two-wire clock hold control.

   always_comb
   begin
      hold_nxt = hold_r;
      unique case (hold_r)
         HOLD_IDLE:
         begin
            if (start_seen)
            begin
               hold_nxt = HOLD_START;
            end
         end
         HOLD_START:
         begin
            if (sck_fall)
            begin
               hold_nxt = HOLD_ARMED;
            end
            else if (clear_start)
            begin
               hold_nxt = HOLD_IDLE;
            end
         end
         HOLD_ARMED:
         begin
            if (clear_start && !start_seen)
            begin
               hold_nxt = HOLD_IDLE;
            end
         end
         default:
         begin
            hold_nxt = HOLD_IDLE;
         end
      endcase
      if (!two_wire)
      begin
         hold_nxt = HOLD_IDLE;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         hold_r <= HOLD_IDLE;
         ovf_hold_r <= 1'b0;
      end
      else if (clk_en)
      begin
         hold_r <= hold_nxt;
         // Overflow hold exists only in the hold variant of two-wire mode.
         ovf_hold_r <= (cfg_r.wire_mode == WIRE_TWO_HOLD)
                       & (wrap | (ovf_hold_r & ~clear_overflow));
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock pin generation and pin drivers.

   // Toggle strobe inverts the clock pin; port bit toggling also works.
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_pin_r <= 1'b0;
      end
      else if (clk_en)
      begin
         clk_pin_r <= (sw_strobe & ctrl.clock_toggle_strobe) ^ clk_pin_r;
      end
   end

   wire logic clk_level = clk_pin_r ^ port_clk_bit;
   wire logic hold_low = (hold_r == HOLD_ARMED) | ovf_hold_r;
   wire logic data_level = out_latch_r & port_data_bit;

   // Two-wire pins are open drain: only ever drive low; no filter applied.
   assign shift_clock_out = two_wire ? 1'b0 : clk_level;
   assign shift_clock_oe = two_wire ? (hold_low | (clk_dir & ~clk_level)) : clk_dir;
   assign serial_data_out = two_wire ? 1'b0 : out_latch_r;
   assign serial_data_oe = two_wire ? (data_dir & ~data_level) : data_dir;

   assign shift_register = shift_r;
   assign serial_status_reg = '{start_detect_flag: start_r, count_overflow_flag: ovf_r,
                                count: cnt_r};
   assign wake_idle = ovf_r | (link_seen & 1'b0);

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   property p_wrap_sets_flag;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && wrap) |=> ovf_r;
   endproperty
   a_wrap_sets_flag: assert property (p_wrap_sets_flag) else $error("overflow flag not set");

   property p_clear_ovf;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && clear_overflow && !wrap) |=> !ovf_r && !ovf_hold_r;
   endproperty
   a_clear_ovf: assert property (p_clear_ovf) else $error("overflow clear failed");

   property p_start_flag;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && start_seen) |=> start_r;
   endproperty
   a_start_flag: assert property (p_start_flag) else $error("start flag not set");

   property p_start_hold;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && two_wire && hold_r == HOLD_START && sck_fall && !ctrl_wr)
         |=> shift_clock_oe && !shift_clock_out;
   endproperty
   a_start_hold: assert property (p_start_hold) else $error("start hold missing");

   property p_count_step;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && cnt_tick && !count_wr_en) |=> cnt_r == $past(cnt_r) + 4'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("counter did not step");

   property p_shift_in;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && do_sample && !data_wr_en)
         |=> shift_r == {$past(shift_r[6:0]), $past(sda_sync_r[1])};
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift wrong");

   property p_write_wins;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && data_wr_en) |=> shift_r == $past(data_wr);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("write lost");

   property p_toggle;
      @(posedge core_clk) disable iff (!rst_n)
      (clk_en && ctrl_wr && ctrl.clock_toggle_strobe) |=> clk_pin_r != $past(clk_pin_r);
   endproperty
   a_toggle: assert property (p_toggle) else $error("clock did not toggle");

   property p_sda_drive;
      @(posedge core_clk) disable iff (!rst_n)
      !data_dir |-> !serial_data_oe;
   endproperty
   a_sda_drive: assert property (p_sda_drive) else $error("data driven without direction");
endmodule
`default_nettype wire

/* tb/spi_far_master.sv */
// Far-side three-wire master: makes the shift clock and swaps one byte per go pulse.
// Assumes raw_clk runs free; the link clock passed on stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module spi_far_master
(
   input wire logic raw_clk,
   input wire logic go,
   input wire logic cpha,
   input wire logic [7:0] tx,
   input wire logic miso,
   output logic link_clk,
   output logic sck,
   output logic mosi,
   output logic [7:0] rx,
   output logic busy
);
   logic run;
   assign link_clk = raw_clk & run;
   initial
   begin
      run = 1'h0;
      sck = 1'h0;
      mosi = 1'h0;
      rx = 8'h00;
      busy = 1'h0;
   end
   always @(posedge go)
   begin
      busy = 1'h1;
      rx = 8'h00;
      @(negedge raw_clk);
      run = 1'h1;
      mosi = tx[7];
      repeat (2) @(posedge raw_clk);
      for (int i = 7; i >= 0; i--)
      begin
         sck = 1'h1;
         if (cpha)
            mosi = tx[i];
         else
            rx = {rx[6:0], miso};
         repeat (2) @(posedge raw_clk);
         sck = 1'h0;
         if (cpha)
            rx = {rx[6:0], miso};
         else if (i > 0)
            mosi = tx[i - 1];
         repeat (2) @(posedge raw_clk);
      end
      // A released line shows the inverse of its last level, never a held copy.
      mosi = ~mosi;
      @(negedge raw_clk);
      run = 1'h0;
      busy = 1'h0;
   end
endmodule
`default_nettype wire

/* tb/universal_serial_shift_unit_test.sv */
// Testbench for the shift unit: three-wire swaps, software clocking, two-wire holds.
// Assumes the far-side master model; two-wire lines are resolved here as open drain.
`timescale 1ns/100ps
`default_nettype none
module universal_serial_shift_unit_test;
   import shift_unit_pkg::*;
   logic core_clk = 1'h0, rst_n = 1'h0, link_raw = 1'h0, go = 1'h0, cpha = 1'h0;
   logic two_w = 1'h0, m_scl = 1'h1, m_sda = 1'h1, s0, data_dir = 1'h1;
   logic ctrl_wr = 1'h0, data_wr_en = 1'h0, count_wr_en = 1'h0;
   logic clear_overflow = 1'h0, clear_start = 1'h0, clk_dir = 1'h0, port_clk_bit = 1'h1;
   logic [7:0] data_wr = 8'h00, p_tx = 8'h00;
   logic [3:0] count_wr = 4'h0;
   serial_control_s ctrl = '0;
   logic shift_clock_out, shift_clock_oe, serial_data_out, serial_data_oe, wake_idle;
   logic p_link, p_sck, p_mosi, p_busy;
   logic [7:0] shift_register, p_rx;
   serial_status_s st;
   int miscompares = 0, n_checks = 0, cycles = 0, i;
   wire scl_bus = m_scl & ~(shift_clock_oe & ~shift_clock_out);
   wire sda_bus = m_sda & ~(serial_data_oe & ~serial_data_out);
   wire sck_in = two_w ? scl_bus : p_sck;
   wire sdi_in = two_w ? sda_bus : p_mosi;
   initial
   begin
      forever #25 core_clk = ~core_clk;
   end
   initial
   begin
      #37;
      forever #80 link_raw = ~link_raw;
   end
   universal_serial_shift_unit dut_u (.core_clk(core_clk), .rst_n(rst_n), .clk_en(1'h1),
      .link_clk(p_link), .ctrl(ctrl), .ctrl_wr(ctrl_wr), .data_wr(data_wr),
      .data_wr_en(data_wr_en), .count_wr(count_wr), .count_wr_en(count_wr_en),
      .clear_overflow(clear_overflow), .clear_start(clear_start),
      .port_clk_bit(port_clk_bit), .port_data_bit(1'h1), .clk_dir(clk_dir),
      .data_dir(data_dir), .serial_data_in(sdi_in), .shift_clock_in(sck_in),
      .shift_clock_out(shift_clock_out), .shift_clock_oe(shift_clock_oe),
      .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
      .shift_register(shift_register), .serial_status_reg(st), .wake_idle(wake_idle));
   spi_far_master far_u (.raw_clk(link_raw), .go(go), .cpha(cpha), .tx(p_tx),
      .miso(serial_data_out), .link_clk(p_link), .sck(p_sck), .mosi(p_mosi),
      .rx(p_rx), .busy(p_busy));
   ////////////////////////////////////////////////////////////////////////////////
   task tally_and_finish();
      if (miscompares == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task wr_ctrl(input serial_control_s c);
      ctrl = c;
      ctrl_wr = 1'h1;
      tick(1);
      ctrl_wr = 1'h0;
      tick(1);
   endtask
   task sw(input logic [7:0] d, input logic de, input logic [3:0] c, input logic ce,
      input logic co, input logic cs);
      data_wr = d;
      data_wr_en = de;
      count_wr = c;
      count_wr_en = ce;
      clear_overflow = co;
      clear_start = cs;
      tick(1);
      data_wr_en = 1'h0;
      count_wr_en = 1'h0;
      clear_overflow = 1'h0;
      clear_start = 1'h0;
      tick(1);
   endtask
   // The counter is cleared and the byte loaded well before the first clock edge.
   task xfer(input logic ph, input logic [7:0] mtx, input logic [7:0] stx);
      sw(stx, 1'h1, 4'h0, 1'h1, 1'h1, 1'h0);
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h1, ph, 1'h0, 1'h0});
      cpha = ph;
      p_tx = mtx;
      go = 1'h1;
      tick(1);
      go = 1'h0;
      for (i = 0; i < 400 && p_busy; i++)
         tick(1);
      tick(6);
      chk("rx", shift_register, mtx);
      chk("tx", p_rx, stx);
      chk("cnt", {4'h0, st.count}, 8'h00);
      chk("ovf", {7'h0, st.count_overflow_flag}, 8'h01);
      chk("wake", {7'h0, wake_idle}, 8'h01);
      sw(8'h00, 1'h0, 4'h0, 1'h0, 1'h1, 1'h0);
      chk("ovf_clr", {7'h0, st.count_overflow_flag}, 8'h00);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 4000)
      begin
         miscompares++;
         tally_and_finish();
      end
   end
   initial
   begin
      tick(5);
      rst_n = 1'h1;
      tick(1);
      chk("rst_sr", shift_register, 8'h00);
      chk("rst_st", {2'h0, st}, 8'h00);
      sw(8'h96, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0);
      chk("live", shift_register, 8'h96);
      xfer(1'h0, 8'ha5, 8'h3c);
      xfer(1'h1, 8'h5a, 8'hc3);
      clk_dir = 1'h1;
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h0, 1'h0, 1'h0, 1'h0});
      sw(8'h81, 1'h1, 4'he, 1'h1, 1'h0, 1'h0);
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h0, 1'h0, 1'h1, 1'h0});
      chk("sw_sr", {1'h0, shift_register[7:1]}, 8'h01);
      chk("sw_cnt", {4'h0, st.count}, 8'h0f);
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h0, 1'h0, 1'h1, 1'h0});
      chk("sw_ovf", {7'h0, st.count_overflow_flag}, 8'h01);
      s0 = shift_clock_out;
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h0, 1'h0, 1'h0, 1'h1});
      chk("toggle", {7'h0, shift_clock_out}, {7'h0, ~s0});
      // External clock with strobe counting: every toggle write counts once.
      sw(8'h00, 1'h0, 4'h0, 1'h1, 1'h0, 1'h0);
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h1, 1'h0, 1'h1, 1'h1});
      wr_ctrl(serial_control_s'{WIRE_THREE, 1'h1, 1'h0, 1'h1, 1'h1});
      chk("strobe_cnt", {4'h0, st.count}, 8'h02);
      data_dir = 1'h0;
      tick(1);
      chk("do_dir", {7'h0, serial_data_oe}, 8'h00);
      data_dir = 1'h1;
      // The slave must not drive the clock line from its port bit in two-wire mode.
      clk_dir = 1'h0;
      two_w = 1'h1;
      wr_ctrl(serial_control_s'{WIRE_TWO_HOLD, 1'h1, 1'h0, 1'h0, 1'h0});
      sw(8'h00, 1'h1, 4'h0, 1'h0, 1'h1, 1'h1);
      chk("sda_lo", {7'h0, sda_bus}, 8'h00);
      sw(8'hff, 1'h1, 4'h0, 1'h0, 1'h0, 1'h0);
      chk("sda_hi", {7'h0, sda_bus}, 8'h01);
      m_sda = 1'h0;
      tick(6);
      chk("start", {7'h0, st.start_detect_flag}, 8'h01);
      m_scl = 1'h0;
      tick(6);
      m_scl = 1'h1;
      tick(6);
      chk("hold_st", {7'h0, scl_bus}, 8'h00);
      m_sda = 1'h1;
      sw(8'h80, 1'h1, 4'he, 1'h1, 1'h0, 1'h0);
      sw(8'h00, 1'h0, 4'h0, 1'h0, 1'h0, 1'h1);
      // The master waits for the clock line to really rise before going on.
      for (i = 0; i < 20 && !scl_bus; i++)
         tick(1);
      chk("st_clr", {7'h0, st.start_detect_flag}, 8'h00);
      tick(6);
      chk("sda_in", shift_register, 8'h01);
      m_scl = 1'h0;
      tick(6);
      m_scl = 1'h1;
      tick(6);
      chk("hold_ov", {7'h0, scl_bus}, 8'h00);
      chk("ovf_2w", {7'h0, st.count_overflow_flag}, 8'h01);
      sw(8'h00, 1'h0, 4'h0, 1'h0, 1'h1, 1'h0);
      tick(2);
      chk("release", {7'h0, scl_bus}, 8'h01);
      tally_and_finish();
   end
endmodule
`default_nettype wire
